// ### brcd_pkg.sv
// Package for the bus relay command decoder: character codes, field widths, reset values.
// Assumes a 7-bit character bus with strobe, qualifier and remote enable lines.
package brcd_pkg;
  localparam int BRCD_CHANNELS = 6;
  localparam logic [6:0] BRCD_CHAR_A = 7'h41;
  localparam logic [6:0] BRCD_CHAR_B = 7'h42;
  localparam logic [6:0] BRCD_DIGIT_ONE = 7'h31;
  localparam logic [6:0] BRCD_DIGIT_SIX = 7'h36;
  localparam logic [6:0] BRCD_LOCKOUT = 7'h11;
  localparam logic [1:0] BRCD_LISTEN_PREFIX = 2'h1;
  localparam logic [4:0] BRCD_ADDR_FORBIDDEN = 5'h1f;
  localparam logic [5:0] BRCD_RELAY_RESET = 6'h00;

  typedef struct packed {
    logic strobe;
    logic command_qualifier_n;
    logic remote_enable_n;
    logic [6:0] data;
  } brcd_char_s;

  typedef enum logic {BRCD_ROW_B, BRCD_ROW_A} brcd_row_e;
endpackage

// ### brcd_char_decode.sv
// Character classifier for the bus relay command decoder.
// Assumes one character per strobe, data stable while strobe is high.
`timescale 1ns/1ps
module brcd_char_decode
  import brcd_pkg::*;
(
  input wire logic [6:0] data,
  input wire logic [4:0] own_addr,
  output logic is_state_a,
  output logic is_state_b,
  output logic is_select,
  output logic [2:0] select_index,
  output logic is_own_listen,
  output logic is_lockout
);
  always_comb begin
    is_state_a = (data == BRCD_CHAR_A);
    is_state_b = (data == BRCD_CHAR_B);
    is_select = (data >= BRCD_DIGIT_ONE) && (data <= BRCD_DIGIT_SIX);
    select_index = 3'(data - BRCD_DIGIT_ONE);
    // All-ones switch setting never matches, it is not a legal address
    is_own_listen = (data[6:5] == BRCD_LISTEN_PREFIX) && (data[4:0] == own_addr)
      && (own_addr != BRCD_ADDR_FORBIDDEN);
    is_lockout = (data == BRCD_LOCKOUT);
  end
endmodule

// ### brcd_top.sv
// Bus relay command decoder: listener, remote/local control and six relay drives.
// Assumes synchronous inputs on ref_clk; one clean strobe pulse per bus character.
`timescale 1ns/1ps
module brcd_top
  import brcd_pkg::*;
#(
  parameter int CHANNELS = BRCD_CHANNELS
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire brcd_char_s bus_in,
  input wire logic [4:0] addr_switch,
  input wire logic [CHANNELS-1:0] panel_switch,
  input wire logic local_reset_press,
  output logic [CHANNELS-1:0] relay_row_a,
  output logic [CHANNELS-1:0] indicator,
  output logic remote_lamp,
  output logic listener_flag,
  output logic front_lockout,
  output logic local_reset
);
  logic is_state_a;
  logic is_state_b;
  logic is_select;
  logic [2:0] select_index;
  logic is_own_listen;
  logic is_lockout;
  brcd_row_e row_sel;
  logic [CHANNELS-1:0] relay;
  logic remote;
  logic cmd_take;
  logic addr_take;

  brcd_char_decode u_decode (
    .data(bus_in.data),
    .own_addr(addr_switch),
    .is_state_a(is_state_a),
    .is_state_b(is_state_b),
    .is_select(is_select),
    .select_index(select_index),
    .is_own_listen(is_own_listen),
    .is_lockout(is_lockout)
  );

  assign addr_take = bus_in.strobe && !bus_in.command_qualifier_n;
  // Relay programming only while addressed and qualifier high
  assign cmd_take = bus_in.strobe && bus_in.command_qualifier_n && listener_flag;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      listener_flag <= 1'b0;
    end else if (addr_take) begin
      listener_flag <= is_own_listen;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      remote <= 1'b0;
    end else if (bus_in.remote_enable_n) begin
      remote <= 1'b0;
    end else if (addr_take && is_own_listen) begin
      remote <= 1'b1;
    end
  end

  // Lockout taken in the addressed command group; remote enable high always lifts it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      front_lockout <= 1'b0;
    end else if (bus_in.remote_enable_n) begin
      front_lockout <= 1'b0;
    end else if (addr_take && is_lockout && listener_flag) begin
      front_lockout <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      row_sel <= BRCD_ROW_A;
    end else if (cmd_take && is_state_a) begin
      row_sel <= BRCD_ROW_A;
    end else if (cmd_take && is_state_b) begin
      row_sel <= BRCD_ROW_B;
    end
  end

  // In local, relays follow switches; on entering remote nothing is reloaded
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      relay <= BRCD_RELAY_RESET;
    end else if (!remote) begin
      relay <= panel_switch;
    end else if (cmd_take && is_select && (int'(select_index) < CHANNELS)) begin
      relay[select_index] <= (row_sel == BRCD_ROW_A);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      relay_row_a <= BRCD_RELAY_RESET;
      indicator <= BRCD_RELAY_RESET;
      remote_lamp <= 1'b0;
      local_reset <= 1'b0;
    end else begin
      relay_row_a <= relay;
      indicator <= relay;
      remote_lamp <= remote;
      local_reset <= local_reset_press && !front_lockout;
    end
  end

  // Select reaches the output two edges after it is taken
  sequence s_select_taken;
    remote && cmd_take && is_select;
  endsequence
  property p_take_select;
    @(posedge ref_clk) disable iff (!rst_n)
    s_select_taken |=> ##1
      relay_row_a[$past(select_index, 2)] == ($past(row_sel, 2) == BRCD_ROW_A);
  endproperty
  a_select_drives_relay: assert property (p_take_select)
    else $error("select did not reach relay");

  a_state_a_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_take && is_state_a |=> row_sel == BRCD_ROW_A)
    else $error("state A not latched");

  a_state_b_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_take && is_state_b |=> row_sel == BRCD_ROW_B)
    else $error("state B not latched");

  a_row_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(cmd_take && (is_state_a || is_state_b)) |=> $stable(row_sel))
    else $error("row changed without state character");

  a_unlisten_foreign: assert property (@(posedge ref_clk) disable iff (!rst_n)
    addr_take && !is_own_listen |=> !listener_flag)
    else $error("listener kept on foreign address");

  a_listen_own: assert property (@(posedge ref_clk) disable iff (!rst_n)
    addr_take && is_own_listen |=> listener_flag)
    else $error("own address not taken");

  sequence s_enter_remote;
    addr_take && is_own_listen && !bus_in.remote_enable_n;
  endsequence
  a_remote_enter: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_enter_remote |=> remote ##1 remote_lamp)
    else $error("remote not entered");

  a_remote_leave: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bus_in.remote_enable_n |=> !remote ##1 !remote_lamp)
    else $error("remote not left");

  a_enter_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(remote) && !(cmd_take && is_select) |=> $stable(relay))
    else $error("relays changed on entering remote");

  a_local_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !remote |=> relay == $past(panel_switch))
    else $error("local relays not following switches");

  a_lockout_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    front_lockout && local_reset_press |=> !local_reset)
    else $error("local reset passed under lockout");

  a_lamp_relay: assert property (@(posedge ref_clk) disable iff (!rst_n)
    indicator == relay_row_a)
    else $error("indicator disagrees with relay");

  a_row_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> relay_row_a == $past(relay))
    else $error("relay output not following relay state");

  a_lamp_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> remote_lamp == $past(remote))
    else $error("remote lamp disagrees with mode");

  // Refused characters must leave the relays alone while remote
  a_remote_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    remote && !(cmd_take && is_select) |=> $stable(relay))
    else $error("relay moved without a select");

  a_cmd_refused: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bus_in.strobe && bus_in.command_qualifier_n && !listener_flag |=> $stable(row_sel))
    else $error("command taken while not listening");

  a_lockout_take: assert property (@(posedge ref_clk) disable iff (!rst_n)
    addr_take && is_lockout && listener_flag && !bus_in.remote_enable_n |=> front_lockout)
    else $error("lockout not taken");

  a_lockout_lift: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bus_in.remote_enable_n |=> !front_lockout)
    else $error("lockout kept with remote enable high");

  a_reset_pass: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !front_lockout |=> local_reset == $past(local_reset_press))
    else $error("local reset not passed");

  sequence s_leave_remote;
    $fell(remote);
  endsequence
  a_leave_loads: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_leave_remote |=> ##1 relay_row_a == $past(panel_switch, 2))
    else $error("switch states not loaded on leaving remote");
endmodule

// ### brcd_ctrl_model.sv
// Bus controller model: one strobe pulse per character, set at the falling edge.
// Assumes the decoder samples bus_out on the rising edge of clk.
`timescale 1ns/1ps
module brcd_ctrl_model
  import brcd_pkg::*;
(
  input wire logic clk,
  output brcd_char_s bus_out
);
  initial bus_out = {1'b0, 1'b0, 1'b1, 7'h00};

  task automatic set_ren(input logic ren_n);
    @(negedge clk);
    bus_out.remote_enable_n <= ren_n;
  endtask

  // Data is not held after the pulse; inverting it exposes stale sampling
  task automatic send(input logic qual_n, input logic [6:0] ch);
    @(negedge clk);
    bus_out.strobe <= 1'b1;
    bus_out.command_qualifier_n <= qual_n;
    bus_out.data <= ch;
    @(negedge clk);
    bus_out.strobe <= 1'b0;
    bus_out.data <= ~ch;
  endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the bus relay command decoder.
// Assumes brcd_pkg, brcd_top and brcd_ctrl_model are compiled first.
`timescale 1ns/1ps
module tb_top
  import brcd_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  brcd_char_s bus_in;
  logic [4:0] addr_switch = 5'h0a;
  logic [5:0] panel_switch = 6'h2d;
  logic local_reset_press = 1'b0;
  logic [5:0] relay_row_a, indicator;
  logic remote_lamp, listener_flag, front_lockout, local_reset;
  int err_count = 0;
  int tests_run = 0;

  always #20 ref_clk = ~ref_clk;

  brcd_ctrl_model ctl_u (.clk(ref_clk), .bus_out(bus_in));
  brcd_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .bus_in(bus_in),
    .addr_switch(addr_switch), .panel_switch(panel_switch),
    .local_reset_press(local_reset_press), .relay_row_a(relay_row_a),
    .indicator(indicator), .remote_lamp(remote_lamp), .listener_flag(listener_flag),
    .front_lockout(front_lockout), .local_reset(local_reset));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic t_local();
    idle(3);
    check("relay", 8'(relay_row_a), 8'h2d);
    panel_switch <= 6'h05;
    idle(3);
    check("indicator", 8'(indicator), 8'h05);
    check("lamp", 8'(remote_lamp), 8'h00);
  endtask

  task automatic t_enter_remote();
    ctl_u.set_ren(1'b0);
    ctl_u.send(1'b0, {BRCD_LISTEN_PREFIX, addr_switch});
    idle(3);
    check("listener", 8'(listener_flag), 8'h01);
    check("lamp", 8'(remote_lamp), 8'h01);
    panel_switch <= 6'h3a;
    idle(3);
    check("relay", 8'(relay_row_a), 8'h05);
  endtask

  // Digits seven and zero sit just outside the select range
  task automatic t_program();
    ctl_u.send(1'b1, BRCD_CHAR_A);
    ctl_u.send(1'b1, BRCD_DIGIT_ONE + 7'h02);
    ctl_u.send(1'b1, BRCD_DIGIT_ONE + 7'h04);
    ctl_u.send(1'b1, BRCD_DIGIT_SIX + 7'h01);
    ctl_u.send(1'b1, BRCD_DIGIT_ONE - 7'h01);
    idle(3);
    check("relay", 8'(relay_row_a), 8'h15);
    ctl_u.send(1'b1, BRCD_CHAR_B);
    ctl_u.send(1'b1, BRCD_DIGIT_ONE + 7'h02);
    ctl_u.send(1'b1, BRCD_DIGIT_ONE);
    idle(3);
    check("relay", 8'(relay_row_a), 8'h10);
    ctl_u.send(1'b1, BRCD_CHAR_A);
    ctl_u.send(1'b1, BRCD_DIGIT_SIX);
    idle(3);
    check("indicator", 8'(indicator), 8'h30);
  endtask

  task automatic t_lockout();
    local_reset_press <= 1'b1;
    ctl_u.send(1'b0, BRCD_LOCKOUT);
    idle(3);
    check("lockout", 8'(front_lockout), 8'h01);
    check("local_reset", 8'(local_reset), 8'h00);
    check("listener", 8'(listener_flag), 8'h00);
    ctl_u.send(1'b1, BRCD_CHAR_B);
    ctl_u.send(1'b1, BRCD_DIGIT_SIX);
    idle(3);
    check("relay", 8'(relay_row_a), 8'h30);
    addr_switch <= BRCD_ADDR_FORBIDDEN;
    ctl_u.send(1'b0, {BRCD_LISTEN_PREFIX, BRCD_ADDR_FORBIDDEN});
    idle(3);
    check("listener", 8'(listener_flag), 8'h00);
    addr_switch <= 5'h0a;
  endtask

  task automatic t_return_local();
    ctl_u.set_ren(1'b1);
    idle(4);
    check("lamp", 8'(remote_lamp), 8'h00);
    check("relay", 8'(relay_row_a), 8'h3a);
    check("lockout", 8'(front_lockout), 8'h00);
    check("local_reset", 8'(local_reset), 8'h01);
  endtask

  initial begin
    idle(3);
    rst_n <= 1'b1;
    t_local();
    t_enter_remote();
    t_program();
    t_lockout();
    t_return_local();
    print_verdict();
  end

  // About 70 cycles are needed; 2000 leaves ample margin
  initial begin
    #80000;
    err_count++;
    print_verdict();
  end
endmodule
